// [flush_regs_pkg.sv]
/*
 * Constants, field layouts and carrier types for the translation-cache
 * flush request registers. Assumes a 32-bit APB register window with
 * 12 address bits and one aligned word per register.
 */
package flush_regs_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] EXT_CAP_OFF = 12'h000;
	localparam logic [11:0] CAP_OFF = 12'h004;
	localparam logic [11:0] CMD_LO_OFF = 12'h008;
	localparam logic [11:0] CMD_HI_OFF = 12'h00C;
	localparam logic [11:0] PAGE_OFF_DEFAULT = 12'h010;

	// ==========================================================
	// Upper command word fields (command bits 63:32)
	localparam int GO_BIT = 31;
	localparam int REQ_GRAN_LSB = 28;
	localparam int ACT_GRAN_LSB = 25;
	localparam int DRAIN_BIT = 16;
	localparam int DOMAIN_LSB = 0;

	// Low page word fields
	localparam int HINT_BIT = 6;
	localparam int MASK_LSB = 0;
	localparam int PAGE_LSB = 12;

	// Capability words
	localparam int PAGE_OFS_LSB = 8;
	localparam int CAP_DRAIN_BIT = 0;
	localparam int CAP_DOMW_LSB = 8;
	localparam int CAP_GUESTW_LSB = 16;
	localparam int CAP_MAXMASK_LSB = 24;

	// ==========================================================
	// Granularity codes
	localparam logic [2:0] GRAN_NONE = 3'h0;
	localparam logic [2:0] GRAN_GLOBAL = 3'h1;
	localparam logic [2:0] GRAN_DOMAIN = 3'h2;
	localparam logic [2:0] GRAN_PAGE = 3'h3;

	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ISSUE = 2'h1,
		ST_WAIT = 2'h3
	} flush_state_e;

	typedef struct packed {
		logic [2:0] gran;
		logic [15:0] domain_tag;
		logic [63:12] page_addr;
		logic [5:0] page_mask_order;
		logic nonleaf_keep_hint;
		logic drain_writes;
	} flush_req_s;

endpackage

// [flush_request_shaper.sv]
/*
 * Shapes the stored register fields into one flush request for the
 * translation cache. Purely combinational; the caller registers it.
 */
module flush_request_shaper
	import flush_regs_pkg::*;
#(
	parameter int GUEST_W = 48,
	parameter int MAX_MASK = 9,
	parameter bit DRAIN_SUP = 1'b1
)
(
	input wire logic [2:0] gran,
	input wire logic [15:0] domain_tag,
	input wire logic drain_writes_ctl,
	input wire logic [63:12] page_addr,
	input wire logic [5:0] page_mask_order,
	input wire logic nonleaf_keep_hint,
	output flush_req_s req,
	output logic legal
);

	logic [63:0] guest_keep;
	logic [63:0] order_clear;
	logic [63:0] addr_full;

	always_comb
	begin
		guest_keep = (64'h1 << GUEST_W) - 64'h1;
		order_clear = ~((64'h1 << (PAGE_LSB + int'(page_mask_order))) - 64'h1);
		addr_full = {page_addr, 12'h000};
		addr_full = addr_full & guest_keep; // RULE_09
		addr_full = addr_full & order_clear; // RULE_12
		req.gran = gran;
		req.domain_tag = domain_tag;
		req.page_addr = addr_full[63:12];
		req.page_mask_order = page_mask_order;
		req.nonleaf_keep_hint = nonleaf_keep_hint; // RULE_10 RULE_11
		req.drain_writes = drain_writes_ctl & DRAIN_SUP; // RULE_01
		// Oversized masks are refused as an incorrect request
		legal = (gran == GRAN_GLOBAL) || (gran == GRAN_DOMAIN) ||
			((gran == GRAN_PAGE) && (int'(page_mask_order) <= MAX_MASK));
	end

endmodule // flush_request_shaper

// [flush_request_regs.sv]
/*
 * APB register front end of the translation-cache flush command and its
 * page-address companion, plus the sequencer that hands one request to
 * the cache and waits for its completion. Assumes the cache logic runs
 * on pclk and answers each request with a single flush_done pulse.
 */
// The APB register port and the register offsets were decided locally.
// Notes on behaviour
// RULE_01: Drain-writes control is ignored when write draining is unsupported.
// RULE_02: With support and control set, the request asks the cache to drain writes.
// RULE_03: Software puts the domain tag in command bits 47:32 before domain or page flush.
// RULE_04: Software keeps the domain tag within the reported domain width.
// RULE_05: Domain tag bits above the supported width are not stored.
// RULE_06: Page-address register is write-only; reads return zero here.
// RULE_07: Page register offset is eight-byte aligned and reported in extended capability.
// RULE_08: Software writes page fields first, then issues the page command.
// RULE_09: Page address bits at and above the guest width are ignored.
// RULE_10: Hint zero flushes leaf and non-leaf cached entries.
// RULE_11: Hint one lets the cache keep non-leaf entries for the range.
// RULE_12: Mask order n clears n address bits from 12, covering 2^n pages.
// RULE_13: Go bit clears on completion; page register is frozen while it is set.
module flush_request_regs
	import flush_regs_pkg::*;
#(
	parameter int DOMAIN_W = 16,
	parameter int GUEST_W = 48,
	parameter int MAX_MASK = 9,
	parameter bit DRAIN_SUP = 1'b1,
	parameter logic [11:0] PAGE_OFF = PAGE_OFF_DEFAULT
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flush_valid,
	output flush_req_s flush_cmd,
	input wire logic flush_done
);

	// ==========================================================
	// Helpers
	function automatic logic [15:0] keep_low16(input logic [15:0] v, input int w);
		logic [15:0] m;
		m = 16'(({17'h0, 16'hFFFF} >> (16 - w)));
		return v & m;
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a[11:2] == off[11:2];
	endfunction

	// ==========================================================
	// State
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic go_q, go_d;
	logic [2:0] req_gran_q, req_gran_d;
	logic [2:0] act_gran_q, act_gran_d;
	logic drain_q, drain_d;
	logic [15:0] domain_q, domain_d;
	logic [63:12] page_q, page_d;
	logic [5:0] order_q, order_d;
	logic hint_q, hint_d;
	flush_state_e state_q, state_d;
	logic flush_valid_q, flush_valid_d;
	flush_req_s flush_cmd_q, flush_cmd_d;

	flush_req_s shaped;
	logic shaped_legal;
	logic setup, wr_en, rd_page, mapped;
	logic [11:0] page_hi_off;

	flush_request_shaper #(
		.GUEST_W(GUEST_W),
		.MAX_MASK(MAX_MASK),
		.DRAIN_SUP(DRAIN_SUP)
	) u_shaper (
		.gran(req_gran_q),
		.domain_tag(domain_q),
		.drain_writes_ctl(drain_q),
		.page_addr(page_q),
		.page_mask_order(order_q),
		.nonleaf_keep_hint(hint_q),
		.req(shaped),
		.legal(shaped_legal)
	);

	// ==========================================================
	// APB slave: answer registered in setup, one access cycle
	always_comb
	begin
		page_hi_off = PAGE_OFF + 12'h004;
		setup = psel & ~penable;
		wr_en = psel & penable & pready_q & pwrite;
		rd_page = hit(paddr, PAGE_OFF) | hit(paddr, page_hi_off);
		mapped = hit(paddr, EXT_CAP_OFF) | hit(paddr, CAP_OFF) |
			hit(paddr, CMD_LO_OFF) | hit(paddr, CMD_HI_OFF) | rd_page;
		pready_d = setup;
		pslverr_d = setup & ~mapped;
		prdata_d = WORD_ZERO;
		if (setup && !pwrite)
		begin
			if (hit(paddr, EXT_CAP_OFF))
				prdata_d[PAGE_OFS_LSB +: 9] = PAGE_OFF[11:3]; // RULE_07
			else if (hit(paddr, CAP_OFF))
			begin
				prdata_d[CAP_DRAIN_BIT] = DRAIN_SUP;
				prdata_d[CAP_DOMW_LSB +: 5] = 5'(DOMAIN_W);
				prdata_d[CAP_GUESTW_LSB +: 7] = 7'(GUEST_W);
				prdata_d[CAP_MAXMASK_LSB +: 6] = 6'(MAX_MASK);
			end
			else if (hit(paddr, CMD_HI_OFF))
			begin
				prdata_d[GO_BIT] = go_q;
				prdata_d[REQ_GRAN_LSB +: 3] = req_gran_q;
				prdata_d[ACT_GRAN_LSB +: 3] = act_gran_q;
				prdata_d[DRAIN_BIT] = drain_q;
				prdata_d[DOMAIN_LSB +: 16] = domain_q;
			end
			// Page words and the low command word read as zero, RULE_06
		end
	end

	// ==========================================================
	// Register writes and flush sequencer
	always_comb
	begin
		go_d = go_q;
		req_gran_d = req_gran_q;
		act_gran_d = act_gran_q;
		drain_d = drain_q;
		domain_d = domain_q;
		page_d = page_q;
		order_d = order_q;
		hint_d = hint_q;
		state_d = state_q;
		flush_valid_d = 1'b0;
		flush_cmd_d = flush_cmd_q;
		// Writes while a flush is pending would corrupt it, so they drop
		if (wr_en && !go_q && state_q == ST_IDLE) // RULE_13
		begin
			if (hit(paddr, CMD_HI_OFF))
			begin
				go_d = pwdata[GO_BIT];
				req_gran_d = pwdata[REQ_GRAN_LSB +: 3];
				drain_d = pwdata[DRAIN_BIT];
				domain_d = keep_low16(pwdata[DOMAIN_LSB +: 16], DOMAIN_W); // RULE_05
			end
			else if (hit(paddr, PAGE_OFF))
			begin
				page_d[31:12] = pwdata[31:12];
				hint_d = pwdata[HINT_BIT];
				order_d = pwdata[MASK_LSB +: 6];
			end
			else if (hit(paddr, page_hi_off))
				page_d[63:32] = pwdata;
		end
		unique case (state_q)
			ST_IDLE:
			begin
				if (go_q && shaped_legal)
				begin
					flush_cmd_d = shaped; // RULE_02
					flush_valid_d = 1'b1;
					state_d = ST_ISSUE;
				end
				else if (go_q)
				begin
					act_gran_d = GRAN_NONE;
					go_d = 1'b0;
				end
			end
			ST_ISSUE:
				state_d = ST_WAIT;
			ST_WAIT:
			begin
				if (flush_done)
				begin
					act_gran_d = flush_cmd_q.gran;
					go_d = 1'b0; // RULE_13
					state_d = ST_IDLE;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= WORD_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			go_q <= 1'b0;
			req_gran_q <= GRAN_NONE;
			act_gran_q <= GRAN_NONE;
			drain_q <= 1'b0;
			domain_q <= 16'h0000;
			page_q <= 52'h0;
			order_q <= 6'h00;
			hint_q <= 1'b0;
			state_q <= ST_IDLE;
			flush_valid_q <= 1'b0;
			flush_cmd_q <= '0;
		end
		else
		begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			go_q <= go_d;
			req_gran_q <= req_gran_d;
			act_gran_q <= act_gran_d;
			drain_q <= drain_d;
			domain_q <= domain_d;
			page_q <= page_d;
			order_q <= order_d;
			hint_q <= hint_d;
			state_q <= state_d;
			flush_valid_q <= flush_valid_d;
			flush_cmd_q <= flush_cmd_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign flush_valid = flush_valid_q;
	assign flush_cmd = flush_cmd_q;

	// ==========================================================
	// Checks
	property p_drain_ignored;
		@(posedge pclk) disable iff (!presetn)
		(flush_valid_q && !DRAIN_SUP) |-> !flush_cmd_q.drain_writes;
	endproperty
	a_drain_ignored: assert property (p_drain_ignored) // RULE_01
		else $error("drain requested without support");

	property p_drain_follows;
		@(posedge pclk) disable iff (!presetn)
		$rose(flush_valid_q) |-> flush_cmd_q.drain_writes == ($past(drain_q) & DRAIN_SUP);
	endproperty
	a_drain_follows: assert property (p_drain_follows) // RULE_02
		else $error("drain flag not taken from control");

	property p_domain_width;
		@(posedge pclk) disable iff (!presetn)
		$rose(go_q) |-> (domain_q >> DOMAIN_W) == 16'h0000;
	endproperty
	a_domain_width: assert property (p_domain_width) // RULE_05
		else $error("domain tag holds bits above width");

	property p_page_reads_zero;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready_q && !pwrite && rd_page) |-> prdata_q == WORD_ZERO;
	endproperty
	a_page_reads_zero: assert property (p_page_reads_zero) // RULE_06
		else $error("page register read returned data");

	property p_ext_offset;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit(paddr, EXT_CAP_OFF))
			|=> prdata_q[PAGE_OFS_LSB +: 9] == PAGE_OFF[11:3];
	endproperty
	a_ext_offset: assert property (p_ext_offset) // RULE_07
		else $error("page register offset misreported");

	property p_order_clear;
		@(posedge pclk) disable iff (!presetn)
		flush_valid_q |-> ((({flush_cmd_q.page_addr, 12'h000}) >> PAGE_LSB)
			& ((64'h1 << flush_cmd_q.page_mask_order) - 64'h1)) == 64'h0;
	endproperty
	a_order_clear: assert property (p_order_clear) // RULE_12
		else $error("masked page bits not cleared");

	property p_guest_width;
		@(posedge pclk) disable iff (!presetn)
		flush_valid_q |-> ({flush_cmd_q.page_addr, 12'h000} >> GUEST_W) == 64'h0;
	endproperty
	a_guest_width: assert property (p_guest_width) // RULE_09
		else $error("address bits above guest width passed");

	property p_hint_follows;
		@(posedge pclk) disable iff (!presetn)
		$rose(flush_valid_q) |-> flush_cmd_q.nonleaf_keep_hint == $past(hint_q);
	endproperty
	a_hint_follows: assert property (p_hint_follows) // RULE_10 RULE_11
		else $error("non-leaf hint not passed on");

	property p_go_clears;
		@(posedge pclk) disable iff (!presetn)
		(state_q == ST_WAIT && flush_done) |=> !go_q ##1 (state_q == ST_IDLE);
	endproperty
	a_go_clears: assert property (p_go_clears) // RULE_13
		else $error("go bit not cleared on completion");

	property p_page_frozen;
		@(posedge pclk) disable iff (!presetn)
		go_q |=> $stable(page_q) && $stable(order_q) && $stable(hint_q);
	endproperty
	a_page_frozen: assert property (p_page_frozen) // RULE_13
		else $error("page register changed while busy");

endmodule // flush_request_regs

// [test_iotlb_invalidation_request_regs.sv]
/*
 * Self-checking bench for the flush request registers: APB master tasks,
 * flush sequences and expected requests. Assumes flush_request_regs with
 * reduced domain and guest widths and a moved page register.
 */
module test_iotlb_invalidation_request_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import flush_regs_pkg::*;

	localparam logic [11:0] PG = 12'h018;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, flush_valid, flush_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	flush_req_s flush_cmd;
	int n_errors = 0;
	int tests_run = 0;

	flush_request_regs #(.DOMAIN_W(8), .GUEST_W(40), .MAX_MASK(9), .DRAIN_SUP(1'b1),
		.PAGE_OFF(PG)) i_flush_request_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flush_valid(flush_valid),
		.flush_cmd(flush_cmd), .flush_done(flush_done));

	// ==========================================================
	// Clock and watchdog
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		#80000;
		n_errors++;
		final_report();
	end

	// ==========================================================
	// Compare and bus tasks
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_req(input flush_req_s e);
		chk("flush_cmd hi", {5'h00, e[78:20]}, {5'h00, flush_cmd[78:20]});
		chk("flush_cmd lo", {44'h0, e[19:0]}, {44'h0, flush_cmd[19:0]});
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait limit here: only the watchdog ends a stuck transfer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", {63'h0, a > 12'h01C}, {63'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Starts a flush, checks the request, optionally pokes the page word
	task automatic flush(input logic [31:0] c, input flush_req_s e, input bit poke);
		apb(1'b1, CMD_HI_OFF, c);
		// A missing request pulse is caught by the watchdog
		do
			@(posedge pclk);
		while (flush_valid !== 1'b1);
		chk_req(e);
		if (poke)
		begin
			apb(1'b0, CMD_HI_OFF, 32'h0);
			chk("go busy", 64'h1, {63'h0, rd[31]});
			apb(1'b1, PG, 32'h00000000);
		end
		flush_done <= 1'b1;
		@(posedge pclk);
		flush_done <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		flush_done = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, EXT_CAP_OFF, 32'h0);
		chk("page offset", 64'h00000300, {32'h0, rd});
		apb(1'b0, CAP_OFF, 32'h0);
		chk("capability", 64'h09280801, {32'h0, rd});
		apb(1'b0, 12'h0F0, 32'h0);
		chk("unmapped", 64'h0, {32'h0, rd});
		// Upper guest bits and domain bits beyond width must vanish
		apb(1'b1, PG, 32'hABCDE043);
		apb(1'b1, PG + 12'h004, 32'hFFFFFFFF);
		apb(1'b0, PG, 32'h0);
		chk("page read", 64'h0, {32'h0, rd});
		flush(32'hB001FFFF, '{3'h3, 16'h00FF, {24'h0, 8'hFF, 20'hABCD8}, 6'h03, 1'b1, 1'b1},
			1'b1);
		apb(1'b0, CMD_HI_OFF, 32'h0);
		chk("cmd done", 64'h360100FF, {32'h0, rd});
		// Page word kept from before the busy poke, drain off
		flush(32'hB0000005, '{3'h3, 16'h0005, {24'h0, 8'hFF, 20'hABCD8}, 6'h03, 1'b1, 1'b0},
			1'b0);
		apb(1'b1, PG, 32'h00001000);
		apb(1'b1, PG + 12'h004, 32'h00000000);
		flush(32'hB0000005, '{3'h3, 16'h0005, 52'h1, 6'h00, 1'b0, 1'b0}, 1'b0);
		// Mask order above the maximum is refused with actual gran zero
		apb(1'b1, PG, 32'h0000000A);
		apb(1'b1, CMD_HI_OFF, 32'hB0000001);
		repeat (6)
		begin
			@(posedge pclk);
			chk("no flush", 64'h0, {63'h0, flush_valid});
		end
		apb(1'b0, CMD_HI_OFF, 32'h0);
		chk("cmd refused", 64'h30000001, {32'h0, rd});
		// Domain-selective flush carries the tag and reports domain granularity
		flush(32'hA0000007, '{3'h2, 16'h0007, 52'h0, 6'h0A, 1'b0, 1'b0}, 1'b0);
		apb(1'b0, CMD_HI_OFF, 32'h0);
		chk("cmd domain", 64'h24000007, {32'h0, rd});
		final_report();
	end
endmodule // test_iotlb_invalidation_request_regs
